// file: hw/adcs_sequencer.sv
// sequencer, result buffers and handshake of the eight-input converter
//
// What this block does
// - trigger write aborts and starts new cycle
// - trigger restarts from first enabled channel
// - config bit 13 selects auto, reset auto
// - direct mode converts each channel once, idles
// - auto mode repeats sequence without triggers
// - trigger, mode change, channel rewrite abort
// - trigger with direct-to-auto change waits
// - each result is 10-bit straight binary
// - staged per channel, copied after last
// - no result update during serial transfer
// - config bits 9:8 hold the rate
// - fixed conversion time, acquisition per rate
// - channel rate is rate over channels
// - auto and direct both use the set rate
// - at most 4 us before first acquisition
// - slower rates nap between conversions
// - direct completion sets ready, pulls pin
// - result read or trigger clears ready
// - auto update gives 1 us pin pulse
// - data valid pin only sinks current
// - per-channel range bit doubles full scale
// - power bit 14 enables converter, reset off
`timescale 1ns/1ps
`default_nettype none

module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter logic [15:0] DEVICE_ID = 16'h0A5C  // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        link_cs_n,
  input  wire logic        link_sclk,
  input  wire logic [9:0]  core_result,
  output logic      [2:0]  core_channel,
  output logic             core_range,
  output logic             core_sample,
  output logic             core_convert,
  output logic             core_nap,
  output logic             core_power,
  output logic             data_valid_n_o,
  output logic             data_valid_n_oe
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] cs_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic       sclk_last_ff;
  logic       clocked_ff;
  wire        frame_act  = ~cs_sync_ff[1];
  wire        sclk_rise  = sclk_sync_ff[1] & ~sclk_last_ff;
  wire        xfer_busy  = frame_act & (clocked_ff | sclk_rise);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_sync_ff   <= 2'h3;
      sclk_sync_ff <= 2'h0;
      sclk_last_ff <= 1'b0;
      clocked_ff   <= 1'b0;
    end else begin
      cs_sync_ff   <= {cs_sync_ff[0], link_cs_n};
      sclk_sync_ff <= {sclk_sync_ff[0], link_sclk};
      sclk_last_ff <= sclk_sync_ff[1];
      clocked_ff   <= frame_act & (clocked_ff | sclk_rise);
    end
  end

  // ==========================================================
  // register decode
  logic              mode_ff;
  logic [1:0]        rate_ff;
  logic [7:0]        enable_ff;
  logic [7:0]        gain_ff;
  logic              power_ff;
  logic              ready_ff;
  logic [7:0][9:0]   data_ff;
  logic [7:0][9:0]   stage_ff;
  adcs_state_t       state_ff;
  logic [2:0]        ch_ff;
  logic [CNT_W-1:0]  cnt_ff;

  wire wr_cfg    = reg_wr & (reg_addr == ADDR_CFG);
  wire wr_enable = reg_wr & (reg_addr == ADDR_ENABLE);
  wire wr_gain   = reg_wr & (reg_addr == ADDR_GAIN);
  wire wr_power  = reg_wr & (reg_addr == ADDR_POWER);
  wire rd_data   = reg_rd & (reg_addr >= ADDR_DATA0)
                          & (reg_addr <= ADDR_DATA7);
  wire new_mode  = reg_wdata[CFG_MODE_BIT];
  wire mode_chg  = wr_cfg & (new_mode != mode_ff);
  wire trig_bit  = wr_cfg & reg_wdata[CFG_TRIG_BIT];
  // trigger with a direct-to-auto change only stops
  wire trig_hold = trig_bit & mode_chg & new_mode;
  wire trig_go   = trig_bit & ~trig_hold & power_ff;
  wire abort     = mode_chg | wr_enable | wr_gain
                 | (wr_power & ~reg_wdata[PWR_ADC_BIT]);

  // ==========================================================
  // channel search, lowest enabled index at or above a start
  function automatic logic [3:0] next_ch(input logic [7:0] en,
                                         input logic [3:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  wire [3:0] first_ch = next_ch(enable_ff, 4'h0);
  wire [3:0] after_ch = next_ch(enable_ff, {1'b0, ch_ff} + 4'h1);

  wire [CNT_W-1:0] acq_len =
    (rate_ff == 2'h0) ? CNT_W'(ACQ0_CYC - 1) :
    (rate_ff == 2'h1) ? CNT_W'(ACQ1_CYC - 1) :
    (rate_ff == 2'h2) ? CNT_W'(ACQ2_CYC - 1) :
                        CNT_W'(ACQ3_CYC - 1);

  wire conv_end = (state_ff == ST_CONV) & (cnt_ff == '0) & ~abort
                & ~trig_go;
  wire seq_last = conv_end & ~after_ch[3];

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff   <= MODE_RST;
      rate_ff   <= RATE_RST;
      enable_ff <= ENABLE_RST;
      gain_ff   <= GAIN_RST;
      power_ff  <= POWER_RST;
    end else begin
      if (wr_cfg) begin
        mode_ff <= new_mode;
        rate_ff <= reg_wdata[CFG_RATE_LO +: 2];
      end
      if (wr_enable) begin
        enable_ff <= reg_wdata[7:0];
      end
      if (wr_gain) begin
        gain_ff <= reg_wdata[7:0];
      end
      if (wr_power) begin
        power_ff <= reg_wdata[PWR_ADC_BIT];
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      ch_ff    <= 3'h0;
      cnt_ff   <= '0;
    end else if (trig_go) begin
      state_ff <= ST_SYNC;
    end else if (abort || !power_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
        end
        ST_SYNC: begin
          // one cycle to settle, well inside the 4 us allowance
          ch_ff    <= first_ch[2:0];
          cnt_ff   <= acq_len;
          state_ff <= first_ch[3] ? ST_ACQ : ST_IDLE;
        end
        ST_ACQ: begin
          if (cnt_ff == '0) begin
            state_ff <= ST_CONV;
            cnt_ff   <= CNT_W'(CONV_CYC - 1);
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_CONV: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (after_ch[3]) begin
            ch_ff    <= after_ch[2:0];
            cnt_ff   <= acq_len;
            state_ff <= ST_ACQ;
          end else if (mode_ff) begin
            ch_ff    <= first_ch[2:0];
            cnt_ff   <= acq_len;
            state_ff <= ST_ACQ;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // two-stage result buffer
  logic copy_pend_ff;
  wire  copy_go = copy_pend_ff & ~xfer_busy;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage_ff     <= '0;
      data_ff      <= '0;
      copy_pend_ff <= 1'b0;
    end else begin
      if (conv_end) begin
        stage_ff[ch_ff] <= core_result;
      end
      if (copy_go) begin
        data_ff <= stage_ff;
      end
      copy_pend_ff <= seq_last | (copy_pend_ff & ~copy_go);
    end
  end

  // ==========================================================
  // handshake flag and data valid pin
  logic              clr_pend_ff;
  logic [CNT_W-1:0]  pulse_ff;
  logic              dv_oe_ff;
  wire  ready_set  = copy_go & ~mode_ff;
  wire  ready_clr  = trig_go | (clr_pend_ff & ~frame_act)
                   | (rd_data & ~frame_act);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ready_ff    <= 1'b0;
      clr_pend_ff <= 1'b0;
      pulse_ff    <= '0;
      dv_oe_ff    <= 1'b1;
    end else begin
      ready_ff    <= ready_set | (ready_ff & ~ready_clr);
      clr_pend_ff <= (clr_pend_ff | rd_data) & frame_act;
      if (copy_go && mode_ff) begin
        pulse_ff <= CNT_W'(PULSE_CYC);
      end else if (pulse_ff != '0) begin
        pulse_ff <= pulse_ff - 1'b1;
      end
      dv_oe_ff <= ~((ready_set | (ready_ff & ~ready_clr))
                    | (copy_go & mode_ff)
                    | (pulse_ff > CNT_W'(1)));
    end
  end

  // ==========================================================
  // register read port
  logic [15:0] rdata_ff;
  wire  [15:0] cfg_word = (16'(mode_ff) << CFG_MODE_BIT)
                        | (16'(rate_ff) << CFG_RATE_LO)
                        | (16'(ready_ff) << CFG_READY_BIT);
  wire  [15:0] nxt_rdata =
    (reg_addr == ADDR_CFG)    ? cfg_word :
    (reg_addr == ADDR_ENABLE) ? {8'h00, enable_ff} :
    (reg_addr == ADDR_GAIN)   ? {8'h00, gain_ff} :
    (reg_addr == ADDR_POWER)  ? 16'(power_ff) << PWR_ADC_BIT :
    (rd_data)                 ? {6'h00, data_ff[reg_addr[2:0]]} :
    (reg_addr == ADDR_ID)     ? DEVICE_ID : 16'h0000;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata       = rdata_ff;
  assign core_channel    = ch_ff;
  assign core_range      = gain_ff[ch_ff];
  assign core_sample     = (state_ff == ST_ACQ);
  assign core_convert    = (state_ff == ST_CONV);
  assign core_nap        = (rate_ff != 2'h0) & (state_ff == ST_ACQ)
                         & (cnt_ff >= CNT_W'(ACQ0_CYC));
  assign core_power      = power_ff;
  assign data_valid_n_o  = 1'b0;
  assign data_valid_n_oe = dv_oe_ff;

  // ==========================================================
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_trig_abort: assert property (trig_go |=> state_ff == ST_SYNC)
    else $error("trigger did not restart the sequencer");
  a_trig_first: assert property (
    (state_ff == ST_SYNC && !abort && !trig_go && power_ff
     && first_ch[3]) |=> ch_ff == $past(first_ch[2:0]))
    else $error("restart did not begin at first channel");
  a_mode_write: assert property (
    wr_cfg |=> mode_ff == $past(new_mode))
    else $error("mode bit not stored");
  a_direct_idle: assert property (
    (seq_last && !mode_ff) |=> state_ff == ST_IDLE)
    else $error("direct mode did not idle after last channel");
  a_trig_hold: assert property (
    trig_hold |=> state_ff == ST_IDLE)
    else $error("trigger with mode change did not stop");
  a_conv_len: assert property (
    (state_ff == ST_ACQ && cnt_ff == '0 && !abort && !trig_go
     && power_ff) |=> (state_ff == ST_CONV
     && cnt_ff == CNT_W'(CONV_CYC - 1)))
    else $error("conversion time wrong");
  a_freeze: assert property (
    xfer_busy |=> $stable(data_ff))
    else $error("results changed during transfer");
  a_ready_set: assert property (
    ready_set |=> ready_ff && !data_valid_n_oe)
    else $error("ready flag or pin not set");
  a_dav_pulse: assert property (
    (copy_go && mode_ff) |=> (!data_valid_n_oe)[*8])
    else $error("auto pulse too short");
  a_power_off: assert property (
    !power_ff |=> state_ff == ST_IDLE || trig_go)
    else $error("converter ran while powered down");
  a_nap_rate: assert property (
    core_nap |-> rate_ff != 2'h0)
    else $error("nap at fastest rate");

  c_direct_done: cover property (ready_set);
  c_auto_pulse:  cover property (copy_go && mode_ff);
  c_mid_trig:    cover property (trig_go && state_ff == ST_CONV);
  c_frozen:      cover property (copy_pend_ff && xfer_busy);

endmodule

`default_nettype wire

// file: hw/adcs_pkg.sv
// constants shared by the converter sequencer
package adcs_pkg;

  // register word addresses
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h01;
  localparam logic [7:0] ADDR_GAIN   = 8'h02;
  localparam logic [7:0] ADDR_POWER  = 8'h03;
  localparam logic [7:0] ADDR_DATA0  = 8'h10;
  localparam logic [7:0] ADDR_DATA7  = 8'h17;
  localparam logic [7:0] ADDR_ID     = 8'h20;

  // field positions of the main configuration and power registers
  localparam int CFG_TRIG_BIT  = 0;
  localparam int CFG_READY_BIT = 7;
  localparam int CFG_RATE_LO   = 8;
  localparam int CFG_MODE_BIT  = 13;
  localparam int PWR_ADC_BIT   = 14;

  // reset values
  localparam logic       MODE_RST   = 1'b1;
  localparam logic [1:0] RATE_RST   = 2'h0;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] GAIN_RST   = 8'h00;
  localparam logic       POWER_RST  = 1'b0;

  // timing, figures in ns and the clock period in ns
  localparam int CLK_NS      = 10;
  localparam int T_CONV_NS   = 1625;
  localparam int T_ACQ0_NS   = 375;
  localparam int T_ACQ1_NS   = 2375;
  localparam int T_ACQ2_NS   = 6375;
  localparam int T_ACQ3_NS   = 14375;
  localparam int T_PULSE_NS  = 1000;
  localparam int CONV_CYC    = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ0_CYC    = (T_ACQ0_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ1_CYC    = (T_ACQ1_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ2_CYC    = (T_ACQ2_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ3_CYC    = (T_ACQ3_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC   = T_PULSE_NS / CLK_NS;
  localparam int CNT_W       = 11;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC,
    ST_ACQ,
    ST_CONV
  } adcs_state_t;

endpackage

// file: tb/adcs_host_link.sv
// host side serial frame generator for the sequencer bench
`timescale 1ns/1ps
`default_nettype none
module adcs_host_link
  import adcs_pkg::*;
(
  input  wire logic       start,
  input  wire logic [7:0] n_clk,
  output logic            link_cs_n,
  output logic            link_sclk,
  output logic            busy
);
  // ==========================================
  // frames; clock stands low outside frames
  initial begin
    link_cs_n = 1'b1;
    link_sclk = 1'b0;
    busy      = 1'b0;
  end
  always @(posedge start) begin
    busy = 1'b1;
    #13 link_cs_n = 1'b0;
    #(T_CONV_NS) link_sclk = 1'b0;  // quiet after conversion start
    repeat (n_clk) begin
      #80 link_sclk = 1'b1;
      #80 link_sclk = 1'b0;
    end
    #80 link_cs_n = 1'b1;
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module testbench
  import adcs_pkg::*;
;
  logic        ref_clk, rstn, reg_wr, reg_rd, frm_start, smp_q, nap_seen;
  logic [7:0]  reg_addr, mask, gain;
  logic [15:0] reg_wdata, reg_rdata, rd_q;
  logic [9:0]  core_result, salt;
  logic [2:0]  core_channel;
  logic        core_range, core_sample, core_convert, core_nap, core_power;
  logic        dv_o, dv_oe, link_cs_n, link_sclk, frm_busy;
  wire logic   dv_pin;
  int          n_fail, checks, seed, exp_ch, t, n;
  int          acq [4] = '{ACQ0_CYC, ACQ1_CYC, ACQ2_CYC, ACQ3_CYC};
  logic [7:0]  ra [5] = '{ADDR_CFG, ADDR_ENABLE, ADDR_POWER, 8'h3F, ADDR_ID};
  logic [15:0] rv [5] = '{16'h2000, 16'h0000, 16'h0000, 16'h0000, 16'h5A3C};

  assign dv_pin = dv_oe ? 1'b1 : dv_o;  // pull-up when released

  adcs_sequencer #(.DEVICE_ID(16'h5A3C)) adcs_sequencer_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_cs_n(link_cs_n), .link_sclk(link_sclk),
    .core_result(core_result), .core_channel(core_channel),
    .core_range(core_range), .core_sample(core_sample),
    .core_convert(core_convert), .core_nap(core_nap),
    .core_power(core_power), .data_valid_n_o(dv_o),
    .data_valid_n_oe(dv_oe));
  adcs_host_link adcs_host_link_inst (.start(frm_start), .n_clk(8'h20),
    .link_cs_n(link_cs_n), .link_sclk(link_sclk), .busy(frm_busy));

  always #5 ref_clk = ~ref_clk;

  function automatic int nxt(input logic [7:0] m, input int from);
    for (int i = 1; i <= 8; i++)
      if (m[(from + i) % 8]) return (from + i) % 8;
    return 0;
  endfunction
  function automatic logic [9:0] res_of(input int ch);
    return salt + 10'(ch) * 10'h05B;
  endfunction
  function automatic logic [15:0] cfgw(input logic md, input logic [1:0] r,
                                       input logic tr);
    return {2'h0, md, 3'h0, r, 7'h00, tr};
  endfunction

  // ==========================================
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a == ADDR_CFG && d[CFG_TRIG_BIT]) exp_ch = nxt(mask, 7);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic go(input logic md, input logic [1:0] r);
    wr(ADDR_ENABLE, {8'h00, mask});
    wr(ADDR_GAIN, {8'h00, gain});
    wr(ADDR_CFG, cfgw(md, r, 1'b0));
    nap_seen = 1'b0;
    wr(ADDR_CFG, cfgw(md, r, 1'b1));
  endtask
  task automatic wait_dv(output int cnt);
    cnt = 0;
    do begin
      @(posedge ref_clk);
      #1 cnt++;
    end while (dv_pin !== 1'b0 && cnt < 20000);
    `CHK("dv wait", 1'b0, dv_pin)
  endtask
  task automatic chk_res;
    for (int c = 0; c < 8; c++)
      if (mask[c]) begin
        rd(ADDR_DATA0 + 8'(c));
        `CHK("result", {6'h00, res_of(c)}, rd_q)
      end
  endtask
  task automatic idle_chk;
    repeat (20) @(posedge ref_clk);
    #1 `CHK("idle", 2'h0, {core_sample, core_convert})
  endtask
  task automatic frame_wait;
    n = 0;
    while (frm_busy && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("frame end", 1'b0, frm_busy)
    frm_start <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================
  // core model and sequence monitor
  always @(posedge ref_clk) begin
    core_result <= res_of(int'(core_channel));
    smp_q <= core_sample;
    if (core_nap === 1'b1) nap_seen = 1'b1;
    if (rstn && core_sample === 1'b1 && smp_q !== 1'b1) begin
      `CHK("channel", 3'(exp_ch), core_channel)
      `CHK("range", gain[core_channel], core_range)
      exp_ch = nxt(mask, int'(core_channel));
    end
  end

  initial begin
    #900000 n_fail++;
    print_verdict;
  end

  // ==========================================
  // main sequence
  initial begin
    {ref_clk, rstn, reg_wr, reg_rd, frm_start, smp_q, nap_seen} = 7'h00;
    {reg_addr, reg_wdata, core_result, mask, gain, salt} = 60'h0;
    {n_fail, checks, exp_ch, seed} = {32'h0, 32'h0, 32'h0, 32'h25};
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK("reset value", rv[i], rd_q)
    end
    wr(ADDR_CFG, cfgw(1'b0, 2'h0, 1'b1));
    idle_chk;
    `CHK("power off", 1'b0, core_power)
    wr(ADDR_POWER, 16'h4000);
    rd(ADDR_POWER);
    `CHK("power on", 2'h3, {rd_q[PWR_ADC_BIT], core_power})
    for (int r = 0; r < 4; r++) begin
      mask = 8'h01 << ($random(seed) & 7);
      gain = 8'($random(seed));
      salt = 10'($random(seed));
      go(1'b0, 2'(r));
      wait_dv(t);
      `CHK("latency", 2 + acq[r] + CONV_CYC, t)
      `CHK("nap", r != 0, nap_seen)
      chk_res;
      @(posedge ref_clk);
      #1 `CHK("pin after read", 1'b1, dv_pin)
    end
    for (int k = 0; k < 3; k++) begin
      mask = 8'($random(seed));
      if (mask == 8'h00) mask = 8'h81;
      gain = 8'($random(seed));
      salt = 10'($random(seed));
      go(1'b0, 2'($random(seed)) & 2'h1);
      wait_dv(t);
      rd(ADDR_CFG);
      `CHK("ready", 1'b1, rd_q[CFG_READY_BIT])
      `CHK("direct idle", 1'b0, core_sample)
      wr(ADDR_CFG, cfgw(1'b0, 2'h0, 1'b1));
      #1 `CHK("pin after trigger", 1'b1, dv_pin)
      wait_dv(t);
      chk_res;
    end
    mask = 8'h04;
    salt = 10'($random(seed));
    go(1'b0, 2'h0);
    frm_start <= 1'b1;
    repeat (1 + ACQ0_CYC + CONV_CYC + 30) @(posedge ref_clk);
    #1 `CHK("frozen pin", 1'b1, dv_pin)
    frame_wait;
    #1 `CHK("pin after frame", 1'b0, dv_pin)
    frm_start <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_res;
    #1 `CHK("pin in frame", 1'b0, dv_pin)
    frame_wait;
    #1 `CHK("pin after read frame", 1'b1, dv_pin)
    mask = 8'h0B;
    go(1'b1, 2'h1);
    wait_dv(t);
    n = 0;
    while (dv_pin === 1'b0 && n < 500) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("pulse", PULSE_CYC, n)
    wait_dv(t);
    `CHK("period", 3 * (ACQ1_CYC + CONV_CYC), n + t)
    rd(ADDR_CFG);
    `CHK("auto cfg", 16'h2100, rd_q)
    n = 0;
    while (!(core_convert === 1'b1 && core_channel === 3'h1) && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    `CHK("mid convert", 4'h9, {core_convert, core_channel})
    wr(ADDR_CFG, cfgw(1'b1, 2'h1, 1'b1));
    #1 `CHK("abort", 1'b0, core_convert)
    repeat (10) @(posedge ref_clk);
    #1 `CHK("restart", 4'h8, {core_sample, core_channel})
    wr(ADDR_ENABLE, 16'h000B);
    idle_chk;
    wr(ADDR_CFG, cfgw(1'b1, 2'h1, 1'b1));
    repeat (300) @(posedge ref_clk);
    wr(ADDR_GAIN, {8'h00, gain});
    idle_chk;
    wr(ADDR_CFG, cfgw(1'b1, 2'h1, 1'b1));
    repeat (300) @(posedge ref_clk);
    wr(ADDR_CFG, cfgw(1'b0, 2'h1, 1'b0));
    idle_chk;
    wr(ADDR_CFG, cfgw(1'b0, 2'h1, 1'b1));
    repeat (100) @(posedge ref_clk);
    wr(ADDR_CFG, cfgw(1'b1, 2'h1, 1'b1));
    idle_chk;
    wr(ADDR_CFG, cfgw(1'b1, 2'h1, 1'b1));
    repeat (100) @(posedge ref_clk);
    wr(ADDR_POWER, 16'h0000);
    idle_chk;
    print_verdict;
  end
endmodule
`default_nettype wire
